//--- fbci_consts.svh
// Timing counts, command codes and address layout for the flash bus host
`ifndef FBCI_CONSTS_SVH
`define FBCI_CONSTS_SVH
`define FBCI_CLK_PERIOD_NS     8
`define FBCI_ACCESS_NS         100
`define FBCI_ACCESS_CYC        ((`FBCI_ACCESS_NS + `FBCI_CLK_PERIOD_NS - 1) / `FBCI_CLK_PERIOD_NS)
`define FBCI_WRPULSE_NS        60
`define FBCI_WRPULSE_CYC       ((`FBCI_WRPULSE_NS + `FBCI_CLK_PERIOD_NS - 1) / `FBCI_CLK_PERIOD_NS)
`define FBCI_RECOVER_NS        24
`define FBCI_RECOVER_CYC       ((`FBCI_RECOVER_NS + `FBCI_CLK_PERIOD_NS - 1) / `FBCI_CLK_PERIOD_NS)
`define FBCI_RSTLOW_NS         1000
`define FBCI_RSTLOW_CYC        ((`FBCI_RSTLOW_NS + `FBCI_CLK_PERIOD_NS - 1) / `FBCI_CLK_PERIOD_NS)
`define FBCI_WAKE_NS           1000
`define FBCI_WAKE_CYC          ((`FBCI_WAKE_NS + `FBCI_CLK_PERIOD_NS - 1) / `FBCI_CLK_PERIOD_NS)
`define FBCI_CMD_READ_ARRAY    8'hff
`define FBCI_CMD_READ_ID       8'h90
`define FBCI_CMD_READ_STATUS   8'h70
`define FBCI_CMD_ERASE_SETUP   8'h20
`define FBCI_CMD_ERASE_CONFIRM 8'hd0
`define FBCI_CMD_PROG_SETUP    8'h40
`define FBCI_STATUS_READY_BIT  7
`define FBCI_BLOCK_LSB         16
`define FBCI_CNT_W             16
`endif

//--- fbci_pkg.sv
// Types shared by the flash bus host
package fbci_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [2:0] {
        FBCI_OP_READ,
        FBCI_OP_READ_STATUS,
        FBCI_OP_READ_ID,
        FBCI_OP_READ_ARRAY_MODE,
        FBCI_OP_ERASE,
        FBCI_OP_PROGRAM,
        FBCI_OP_POWERDOWN
    } fbci_op_t;

    typedef struct packed {
        logic       chipSelN;
        logic       outEnN;
        logic       writeEnN;
        logic       resetPowerdownN;
    } fbci_ctl_t;
endpackage : fbci_pkg

//--- fbci_host.sv
// Host controller that drives the byte-wide flash through its bus pins
`include "fbci_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] Device is in read-array mode after power-up or power-down exit.
// [RULE2] Device's write state machine runs erase, program, lock on its own.
// [RULE3] Device latches address and data during each write cycle.
// [RULE4] Status and identifier reads work at any program supply level.
// [RULE5] At program supply lockout the device refuses all alterations.
// [RULE6] Erase, program, lock need a two-write sequence; host sends both for erase and program, and has no lock request.
// [RULE7] Writes ignored while reset_powerdown_n low or core below lockout.
// [RULE8] Device blocks erase and program to locked blocks.
// [RULE9] Erase suspend allows read or program of other blocks.
// [RULE10] Program suspend allows reads of other array locations.
// [RULE11] Array made of 64-Kbyte blocks; block n starts at n times 0x10000.
// [RULE12] Host writes the read-mode command before status and ID reads; plain array reads send no read-array command first.
// [RULE13] Read data valid only with chip select and output enable both low.
// [RULE14] Device drives data pins only while output enable is active.
// [RULE15] During reads host keeps write enable high, reset_powerdown_n high.
// [RULE16] After power-down exit, read-array mode and status 80H.
// [RULE17] Device latches command on first rising of write or chip enable.
// [RULE18] Data eight bits; address covers eight, sixteen or thirty-two blocks.
module fbci_host
    import fbci_pkg::*;
#(
    parameter int NUM_BLOCKS  = 32,
    parameter int ADDR_W      = $clog2(NUM_BLOCKS) + `FBCI_BLOCK_LSB,
    parameter int RSTLOW_CYC  = `FBCI_RSTLOW_CYC,
    parameter int WAKE_CYC    = `FBCI_WAKE_CYC
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Command port
    input  wire logic              reqValid,
    output      logic              reqReady,
    input  wire fbci_op_t          reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [7:0]        reqData,
    output      logic              rspValid,
    output      logic [7:0]        rspData,
    // Flash pins
    output      logic [ADDR_W-1:0] flashAddr,
    output      fbci_ctl_t         flashCtl,
    input  wire logic [7:0]        dataPinsIn,
    output      logic [7:0]        dataPinsOut,
    output      logic              dataPinsOen
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef enum logic [2:0] {
        ST_RSTLOW, ST_WAKE, ST_IDLE, ST_WRITE, ST_RECOVER, ST_READ
    } fbci_state_t;

    localparam int CW = `FBCI_CNT_W;

    fbci_state_t     state_reg;
    logic [CW-1:0]   count_reg;
    logic            second_reg;
    logic            readAfter_reg;
    fbci_op_t        op_reg;
    logic [7:0]      data_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0]      dataSync1_reg;
    logic [7:0]      dataSync2_reg;

    //////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser
    always_ff @(posedge mclk) begin
        dataSync1_reg <= dataPinsIn;
        dataSync2_reg <= dataSync1_reg;
    end

    // First-write command code for a request
    function automatic logic [7:0] first_code(input fbci_op_t op, input logic [7:0] d);
        case (op)
            FBCI_OP_READ_STATUS: first_code = `FBCI_CMD_READ_STATUS;
            FBCI_OP_READ_ID:     first_code = `FBCI_CMD_READ_ID;
            FBCI_OP_ERASE:       first_code = `FBCI_CMD_ERASE_SETUP;
            FBCI_OP_PROGRAM:     first_code = `FBCI_CMD_PROG_SETUP;
            default:             first_code = `FBCI_CMD_READ_ARRAY;
        endcase
    endfunction : first_code

    assign reqReady = (state_reg == ST_IDLE);

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg     <= ST_RSTLOW;
            count_reg     <= '0;
            second_reg    <= 1'b0;
            readAfter_reg <= 1'b0;
            op_reg        <= FBCI_OP_READ;
            data_reg      <= 8'h00;
            addr_reg      <= '0;
        end else begin
            case (state_reg)
                ST_RSTLOW: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= CW'(RSTLOW_CYC - 1)) begin // RULE7
                        count_reg <= '0;
                        state_reg <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= CW'(WAKE_CYC - 1)) begin // RULE16
                        count_reg <= '0;
                        state_reg <= ST_IDLE; // RULE1
                    end
                end
                ST_IDLE: begin
                    count_reg <= '0;
                    if (reqValid) begin
                        op_reg     <= reqOp;
                        addr_reg   <= reqAddr;
                        data_reg   <= reqData;
                        second_reg <= 1'b0;
                        if (reqOp == FBCI_OP_POWERDOWN) begin
                            state_reg <= ST_RSTLOW;
                        end else if (reqOp == FBCI_OP_READ) begin
                            state_reg <= ST_READ;
                        end else begin
                            // RULE12
                            readAfter_reg <= (reqOp == FBCI_OP_READ_STATUS)
                                          || (reqOp == FBCI_OP_READ_ID);
                            state_reg     <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= CW'(`FBCI_WRPULSE_CYC - 1)) begin // RULE3
                        count_reg <= '0;
                        state_reg <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= CW'(`FBCI_RECOVER_CYC - 1)) begin // RULE17
                        count_reg <= '0;
                        if (!second_reg && (op_reg == FBCI_OP_ERASE
                                         || op_reg == FBCI_OP_PROGRAM)) begin
                            second_reg <= 1'b1; // RULE6
                            state_reg  <= ST_WRITE;
                        end else if (readAfter_reg) begin
                            readAfter_reg <= 1'b0;
                            state_reg     <= ST_READ; // RULE4
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_READ: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= CW'(`FBCI_ACCESS_CYC + 2)) begin // RULE13
                        count_reg <= '0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flashCtl    <= '{chipSelN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1,
                             resetPowerdownN: 1'b0};
            flashAddr   <= '0;
            dataPinsOut <= 8'h00;
            dataPinsOen <= 1'b1;
        end else begin
            flashCtl.resetPowerdownN <= (state_reg != ST_RSTLOW); // RULE15
            flashCtl.chipSelN <= !(state_reg == ST_WRITE || state_reg == ST_READ);
            flashCtl.writeEnN <= (state_reg != ST_WRITE); // RULE17
            flashCtl.outEnN   <= (state_reg != ST_READ); // RULE14
            dataPinsOen       <= (state_reg != ST_WRITE);
            flashAddr         <= (op_reg == FBCI_OP_ERASE)
                               ? {addr_reg[ADDR_W-1:`FBCI_BLOCK_LSB],
                                  {`FBCI_BLOCK_LSB{1'b0}}} // RULE11
                               : addr_reg;
            if (state_reg == ST_WRITE) begin
                dataPinsOut <= second_reg ? ((op_reg == FBCI_OP_ERASE)
                                 ? `FBCI_CMD_ERASE_CONFIRM : data_reg)
                             : first_code(op_reg, data_reg); // RULE18
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read capture
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rspValid <= 1'b0;
            rspData  <= 8'h00;
        end else begin
            rspValid <= 1'b0;
            if (state_reg == ST_READ && count_reg == CW'(`FBCI_ACCESS_CYC + 2)) begin
                rspValid <= 1'b1; // RULE13
                rspData  <= dataSync2_reg;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    a_read_no_write: assert property ( // RULE15
        @(posedge mclk) disable iff (!resetn)
        !flashCtl.outEnN |-> flashCtl.writeEnN && flashCtl.resetPowerdownN)
        else $error("write enable active during read");
    a_write_drives: assert property ( // RULE17
        @(posedge mclk) disable iff (!resetn)
        !flashCtl.writeEnN |-> !dataPinsOen && !flashCtl.chipSelN)
        else $error("write without data drive");
    a_oe_no_drive: assert property ( // RULE14
        @(posedge mclk) disable iff (!resetn)
        !flashCtl.outEnN |-> dataPinsOen)
        else $error("bus conflict on data pins");
    a_erase_two_writes: assert property ( // RULE6
        @(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WRITE && !second_reg && op_reg == FBCI_OP_ERASE)
        |-> ##[1:30] (state_reg == ST_WRITE && second_reg))
        else $error("erase confirm missing");
    a_confirm_code: assert property ( // RULE6
        @(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WRITE && second_reg && op_reg == FBCI_OP_ERASE)
        |=> dataPinsOut == `FBCI_CMD_ERASE_CONFIRM)
        else $error("wrong erase confirm code");
    a_status_mode_first: assert property ( // RULE12
        @(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WRITE && op_reg == FBCI_OP_READ_STATUS)
        |=> dataPinsOut == `FBCI_CMD_READ_STATUS)
        else $error("status mode not written");
    a_erase_block_addr: assert property ( // RULE11
        @(posedge mclk) disable iff (!resetn)
        (state_reg == ST_WRITE && op_reg == FBCI_OP_ERASE)
        |=> flashAddr[`FBCI_BLOCK_LSB-1:0] == '0)
        else $error("erase address not block aligned");
    a_read_pulse: assert property ( // RULE13
        @(posedge mclk) disable iff (!resetn)
        rspValid |-> $past(state_reg) == ST_READ && !flashCtl.chipSelN)
        else $error("response outside read");
    c_erase: cover property (@(posedge mclk) state_reg == ST_WRITE && second_reg
        && op_reg == FBCI_OP_ERASE);
    c_status: cover property (@(posedge mclk) rspValid && op_reg == FBCI_OP_READ_STATUS);
    c_powerdown: cover property (@(posedge mclk) resetn && state_reg == ST_RSTLOW);
endmodule : fbci_host

//--- fbci_flash_model.sv
// Behavioural model of the byte-wide flash seen from its bus pins
`include "fbci_consts.svh"
module fbci_flash_model
    import fbci_pkg::*;
#(
    parameter int         ADDR_W       = 21,
    parameter int         LOCKED_BLOCK = 31,
    parameter logic [7:0] MFR_CODE     = 8'h5a // Arbitrary value
) (
    // Sampling clock
    input  wire logic              mclk,
    // Pins from host
    input  wire logic [ADDR_W-1:0] addr,
    input  wire fbci_ctl_t         ctl,
    input  wire logic [7:0]        busIn,
    // Program supply above lockout level
    input  wire logic              progSupplyOk,
    // Data pins back to host
    output      logic [7:0]        dataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]        mem [int];
    logic [7:0]        mode;
    logic [7:0]        pend;
    logic [7:0]        latchD;
    logic [7:0]        lastOut;
    logic [7:0]        rdVal;
    logic [ADDR_W-1:0] latchA;
    logic              wrActive;
    logic              drive;
    int                base;
    //////////////////////////////////////////////////////////////////////////
    assign wrActive = !ctl.chipSelN && !ctl.writeEnN && ctl.resetPowerdownN;
    assign drive = !ctl.chipSelN && !ctl.outEnN && ctl.resetPowerdownN;
    initial begin
        mode = 8'hff;
        pend = 8'h00;
    end
    always @(posedge mclk) begin
        if (wrActive) begin
            latchA <= addr;
            latchD <= busIn;
        end
    end
    // Command decode on end of write cycle
    always @(negedge wrActive or negedge ctl.resetPowerdownN) begin
        if (!ctl.resetPowerdownN) begin
            mode = 8'hff;
            pend = 8'h00;
        end else if (pend != 8'h00) begin
            base = int'(latchA >> `FBCI_BLOCK_LSB);
            if (!progSupplyOk) begin
                base = base;
            end else if (base != LOCKED_BLOCK && pend == 8'h40) begin
                mem[int'(latchA)] = latchD;
            end else if (base != LOCKED_BLOCK && latchD == 8'hd0) begin
                for (int k = 0; k < 65536; k++) begin
                    mem.delete((base << `FBCI_BLOCK_LSB) + k);
                end
            end
            pend = 8'h00;
            mode = 8'h70;
        end else if (latchD == 8'h20 || latchD == 8'h40) begin
            pend = latchD;
        end else begin
            mode = latchD;
        end
    end
    always @* begin
        case (mode)
            8'h90:   rdVal = (addr == '0) ? MFR_CODE : 8'h00;
            8'h70:   rdVal = 8'h80;
            default: rdVal = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
        endcase
    end
    // Undriven pins show a changing pattern
    assign dataOut = drive ? rdVal : ~lastOut;
    always @(posedge mclk) lastOut <= dataOut;
endmodule : fbci_flash_model

//--- fbci_host_bench.sv
// Self-checking bench for the flash bus host
module fbci_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fbci_pkg::*;
    typedef struct {
        fbci_op_t    op;
        logic [20:0] a;
        logic [7:0]  d;
        logic        rd;
        logic [7:0]  e;
    } fbci_row_t;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        progSupplyOk = 1'b1;
    logic        reqValid = 1'b0;
    logic        reqReady;
    fbci_op_t    reqOp = FBCI_OP_READ;
    logic [20:0] reqAddr = '0;
    logic [7:0]  reqData = '0;
    logic        rspValid;
    logic [7:0]  rspData;
    logic [20:0] flashAddr;
    fbci_ctl_t   flashCtl;
    logic [7:0]  dataPinsOut;
    logic        dataPinsOen;
    logic [7:0]  devOut;
    wire  [7:0]  dataPinsIn = !dataPinsOen ? dataPinsOut : devOut;
    int          n_mismatch = 0;
    int          checks = 0;
    fbci_row_t   rows [17];
    //////////////////////////////////////////////////////////////////////////
    always #4 mclk = ~mclk;
    fbci_host #(.NUM_BLOCKS(32), .RSTLOW_CYC(4), .WAKE_CYC(4)) i_fbci_host (
        .mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
        .rspData(rspData), .flashAddr(flashAddr), .flashCtl(flashCtl),
        .dataPinsIn(dataPinsIn), .dataPinsOut(dataPinsOut), .dataPinsOen(dataPinsOen));
    fbci_flash_model i_fbci_flash_model (.mclk(mclk), .addr(flashAddr), .ctl(flashCtl),
        .busIn(dataPinsIn), .progSupplyOk(progSupplyOk), .dataOut(devOut));
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic wait_hi(input logic rsp, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((rsp ? rspValid : reqReady) !== 1'b1 && n < lim);
        if ((rsp ? rspValid : reqReady) !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_hi
    task automatic run(input fbci_row_t r);
        wait_hi(1'b0, 3000);
        reqValid <= 1'b1;
        reqOp    <= r.op;
        reqAddr  <= r.a;
        reqData  <= r.d;
        wait_hi(1'b0, 3000);
        reqValid <= 1'b0;
        if (r.rd) begin
            wait_hi(1'b1, 200);
            chk(rspData, r.e);
            @(posedge mclk);
            chk({7'h0, rspValid}, 8'h00);
        end
    endtask : run
    // Reads keep write enable and reset pin high, no bus contention
    always @(posedge mclk) begin
        if (resetn && flashCtl.outEnN === 1'b0) begin
            chk({7'h0, flashCtl.writeEnN & dataPinsOen & flashCtl.resetPowerdownN}, 8'h01);
        end
    end
    initial begin
        rows = '{
            '{FBCI_OP_PROGRAM, 21'h000010, 8'ha5, 1'b0, 8'h00},
            '{FBCI_OP_PROGRAM, 21'h010000, 8'h3c, 1'b0, 8'h00},
            '{FBCI_OP_PROGRAM, 21'h1fffff, 8'h77, 1'b0, 8'h00},
            '{FBCI_OP_READ_STATUS, 21'h000000, 8'h00, 1'b1, 8'h80},
            '{FBCI_OP_READ_ARRAY_MODE, 21'h000000, 8'h00, 1'b0, 8'h00},
            '{FBCI_OP_READ, 21'h000010, 8'h00, 1'b1, 8'ha5},
            '{FBCI_OP_READ, 21'h010000, 8'h00, 1'b1, 8'h3c},
            '{FBCI_OP_READ, 21'h1fffff, 8'h00, 1'b1, 8'hff},
            '{FBCI_OP_READ_ID, 21'h000000, 8'h00, 1'b1, 8'h5a},
            '{FBCI_OP_ERASE, 21'h000123, 8'h00, 1'b0, 8'h00},
            '{FBCI_OP_READ_ARRAY_MODE, 21'h000000, 8'h00, 1'b0, 8'h00},
            '{FBCI_OP_READ, 21'h000010, 8'h00, 1'b1, 8'hff},
            '{FBCI_OP_READ, 21'h010000, 8'h00, 1'b1, 8'h3c},
            '{FBCI_OP_READ_ID, 21'h000000, 8'h00, 1'b1, 8'h5a},
            '{FBCI_OP_POWERDOWN, 21'h000000, 8'h00, 1'b0, 8'h00},
            '{FBCI_OP_READ, 21'h010000, 8'h00, 1'b1, 8'h3c},
            '{FBCI_OP_READ_STATUS, 21'h000000, 8'h00, 1'b1, 8'h80}
        };
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk({4'h0, flashCtl}, 8'h0e);
        chk({7'h0, dataPinsOen}, 8'h01);
        foreach (rows[i]) run(rows[i]);
        // Program supply lockout refuses alteration, status still reads
        progSupplyOk <= 1'b0;
        run(fbci_row_t'{FBCI_OP_PROGRAM, 21'h000020, 8'h11, 1'b0, 8'h00});
        run(fbci_row_t'{FBCI_OP_READ_STATUS, 21'h000000, 8'h00, 1'b1, 8'h80});
        run(fbci_row_t'{FBCI_OP_READ_ARRAY_MODE, 21'h000000, 8'h00, 1'b0, 8'h00});
        run(fbci_row_t'{FBCI_OP_READ, 21'h000020, 8'h00, 1'b1, 8'hff});
        progSupplyOk <= 1'b1;
        // Reset mid-run brings device back to array reads
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk({4'h0, flashCtl}, 8'h0e);
        chk({6'h0, reqReady, rspValid}, 8'h00);
        run(rows[15]);
        print_verdict();
    end
endmodule : fbci_host_bench
